// File: bench/lcp_panel_model.sv
// lcd panel electrode model facing the pin control outputs
`timescale 1ns/10ps
module lcp_panel_model (
	// clock
	input  wire         clk_sys_i,
	// pins from the bank
	input  wire  [23:0] lcd_pin_select_i,
	input  wire  [47:0] lcd_pin_level_i,
	// level seen at each electrode
	output logic [47:0] panel_drive_o
);
	logic [47:0] last_reg = 48'h000000000000;
	// pin only when selected
	// a released pin floats, so show the inverse of its last level
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			panel_drive_o[2*i+:2] = lcd_pin_select_i[i] ? lcd_pin_level_i[2*i+:2] : ~last_reg[2*i+:2];
		end
	end
	// keep the last level actually driven, so a released pin shows its inverse
	always @(posedge clk_sys_i) begin
		for (int i = 0; i < 24; i++) begin
			if (lcd_pin_select_i[i])
				last_reg[2*i+:2] <= lcd_pin_level_i[2*i+:2];
		end
	end
endmodule // lcp_panel_model

// File: bench/lcp_pin_ctrl_properties.sv
// port assertions for the lcd pin control bank
`timescale 1ns/10ps
module lcp_pin_ctrl_properties (
	// watched ports
	input wire        clk_sys_i,
	input wire        rstn_i,
	input wire [2:0]  reg_addr_i,
	input wire [7:0]  reg_wdata_i,
	input wire        reg_wr_i,
	input wire        reg_rd_i,
	input wire [7:0]  reg_rdata_o,
	input wire [23:0] io_data_i,
	input wire [23:0] lcd_pin_select_o,
	input wire [23:0] lcd_pin_is_segment_o,
	input wire [47:0] lcd_pin_level_o,
	input wire [1:0]  bias_current_select_o,
	input wire        lcd_master_enable_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	rdata_idle_a: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("stray read data");
	master_copy_a: assert property (
		reg_wr_i && reg_addr_i == 3'h0 |-> ##2 lcd_master_enable_o == $past(reg_wdata_i[4], 2))
		else $error("master enable wrong");
	bias_copy_a: assert property (
		reg_wr_i && reg_addr_i == 3'h0 |-> ##2 bias_current_select_o == $past(reg_wdata_i[6:5], 2))
		else $error("bias select wrong");
	master_off_vss_a: assert property (
		!lcd_master_enable_o |-> lcd_pin_select_o == 24'h000000 && lcd_pin_level_o == 48'h0)
		else $error("pins live with master off");
	seg_role_fixed_a: assert property (
		$past(rstn_i, 2) |-> lcd_pin_is_segment_o[23:6] == 18'h3FFFF) else $error("role wrong");
	high_unimpl_a: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) == 3'h4 |-> reg_rdata_o[7:2] == 6'h00)
		else $error("unused bits set");
	unmapped_zero_a: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) > 3'h5 |-> reg_rdata_o == 8'h00)
		else $error("unmapped data");
	reg_readback_a: assert property (
		reg_wr_i && reg_addr_i == 3'h2 ##1 !reg_wr_i ##1 reg_rd_i && reg_addr_i == 3'h2
		|=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("readback wrong");
endmodule // lcp_pin_ctrl_properties

bind lcp_pin_ctrl lcp_pin_ctrl_properties lcp_pin_ctrl_properties_inst (
	.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .io_data_i(io_data_i),
	.lcd_pin_select_o(lcd_pin_select_o), .lcd_pin_is_segment_o(lcd_pin_is_segment_o),
	.lcd_pin_level_o(lcd_pin_level_o), .bias_current_select_o(bias_current_select_o),
	.lcd_master_enable_o(lcd_master_enable_o));

// File: bench/tb_lcp_pin_ctrl.sv
// self-checking bench for the lcd pin control bank
`timescale 1ns/10ps
module tb_lcp_pin_ctrl;
	logic        clk = 1'h0, rstn = 1'h0, wstb = 1'h0, rstb = 1'h0, men;
	logic [2:0]  addr = 3'h0;
	logic [7:0]  wdata = 8'h00, rdata;
	logic [23:0] io = 24'h000000, sel, seg;
	logic [47:0] lvl, drive;
	logic [1:0]  bias;
	int          fail_count = 0, checks_done = 0;
	logic [7:0]  rexp [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hE0, 8'h00, 8'h00};
	logic [7:0]  smask [8] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0]  rdata_s;
	logic [23:0] sel_s;
	logic [7:0]  tm [6] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'h7F};
	logic [7:0]  tr [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hC0, 8'hC0, 8'hC0};
	logic        tio [6] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
	logic [47:0] tl [6] = '{48'hFFFFFFFFFFFF, 48'h555555555555, 48'hAAAAAAAAAAAA,
		48'h000000000FFF, 48'hFFFFFFFFF000, 48'hAAAAAAAAA555};

	always #12.5 clk = ~clk;

	lcp_pin_ctrl lcp_pin_ctrl_inst (
		.clk_sys_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wstb),
		.reg_rd_i(rstb), .reg_rdata_o(rdata), .io_data_i(io), .lcd_pin_select_o(sel),
		.lcd_pin_is_segment_o(seg), .lcd_pin_level_o(lvl), .bias_current_select_o(bias),
		.lcd_master_enable_o(men));
	// small variant beside the large one, fed by the same bus
	lcp_pin_ctrl #(.LARGE_VARIANT(0)) lcp_pin_ctrl_small_inst (
		.clk_sys_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wstb),
		.reg_rd_i(rstb), .reg_rdata_o(rdata_s), .io_data_i(io), .lcd_pin_select_o(sel_s),
		.lcd_pin_is_segment_o(), .lcd_pin_level_o(), .bias_current_select_o(),
		.lcd_master_enable_o());
	lcp_panel_model lcp_panel_model_inst (.clk_sys_i(clk), .lcd_pin_select_i(sel),
		.lcd_pin_level_i(lvl), .panel_drive_o(drive));

	task chk(input string n, input logic [47:0] e, input logic [47:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wstb <= 1'h1;
		@(posedge clk);
		wstb <= 1'h0;
	endtask
	// read data stands only in the cycle after the strobe
	task rd_chk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rstb <= 1'h1;
		@(posedge clk);
		rstb <= 1'h0;
		#1 chk("read data", e, rdata);
		chk("small read data", e & smask[a], rdata_s);
	endtask
	// io data needs three edges, so five covers writes too
	task settle;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		stop_test;
	end

	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'h1;
		for (int a = 0; a < 8; a++) rd_chk(a[2:0], 8'h00);
		wr(3'h2, 8'h5A);
		rd_chk(3'h2, 8'h5A);
		$display("test reset and readback done");
		for (int a = 0; a < 8; a++) wr(a[2:0], 8'hFF);
		for (int a = 0; a < 8; a++) rd_chk(a[2:0], rexp[a]);
		settle;
		chk("select", 48'hFFFFFF, sel);
		chk("small select", 48'h0FFFFF, sel_s);
		chk("role", 48'hFFFFFF, seg);
		chk("enable", 48'h1, men);
		for (int b = 0; b < 4; b++) begin
			wr(3'h0, {1'h1, b[1:0], 5'h1F});
			settle;
			chk("bias", b[1:0], bias);
		end
		$display("test register map done");
		for (int i = 0; i < 6; i++) begin
			wr(3'h0, tm[i]);
			wr(3'h1, tr[i]);
			io <= {24{tio[i]}};
			settle;
			chk("level", tl[i], lvl);
			chk("electrode", tl[i], drive);
		end
		$display("test levels done");
		wr(3'h0, 8'h6F);
		settle;
		chk("level off", 48'h0, lvl);
		chk("select off", 48'h0, sel);
		chk("electrode off", 48'h555555555AAA, drive);
		for (int a = 1; a < 5; a++) wr(a[2:0], 8'h00);
		wr(3'h0, 8'h91);
		io <= 24'h000000;
		settle;
		chk("one pin", 48'h1, sel);
		chk("one level", 48'h2, lvl);
		$display("test master and pin select done");
		stop_test;
	end
endmodule // tb_lcp_pin_ctrl

// File: hdl/lcp_level_sel.v
// drive level selection for one lcd common or segment pin
`timescale 1ns/10ps

module lcp_level_sel (
	// control
	input  wire       master_en_i,
	input  wire       frame_i,
	input  wire       pin_en_i,
	input  wire       is_segment_i,
	input  wire       io_data_i,
	// level
	output reg  [1:0] level_o
);
`include "lcp_map.vh"

	// frame 0: common vdd/third, segment vss/two thirds; frame 1 swaps
	always @* begin
		level_o = `LCP_LVL_VSS;
		if (master_en_i && pin_en_i) begin
			case ({frame_i, is_segment_i})
				2'h0:    level_o = io_data_i ? `LCP_LVL_VDD : `LCP_LVL_THIRD;
				2'h1:    level_o = io_data_i ? `LCP_LVL_VSS : `LCP_LVL_TWO_THIRDS;
				2'h2:    level_o = io_data_i ? `LCP_LVL_VSS : `LCP_LVL_TWO_THIRDS;
				default: level_o = io_data_i ? `LCP_LVL_VDD : `LCP_LVL_THIRD;
			endcase
		end
	end

endmodule // lcp_level_sel

// File: hdl/lcp_map.vh
// register offsets, field positions and reset values of the lcd pin control bank
`ifndef LCP_MAP_VH
`define LCP_MAP_VH

// ------------------------------------------------------------
// register offsets (register index on the plain port)
// ------------------------------------------------------------
`define LCP_MAIN_CONTROL_ADDR      3'h0
`define LCP_COMMON_ROLE_ADDR       3'h1
`define LCP_SEG_ENABLE_LOW_ADDR    3'h2
`define LCP_SEG_ENABLE_MID_ADDR    3'h3
`define LCP_SEG_ENABLE_HIGH_ADDR   3'h4
`define LCP_PIN_STATUS_ADDR        3'h5
`define LCP_UNMAPPED_DATA          8'h00

// ------------------------------------------------------------
// field positions in lcd_main_control
// ------------------------------------------------------------
`define LCP_FRAME_BIT              7
`define LCP_BIAS_SEL_HI            6
`define LCP_BIAS_SEL_LO            5
`define LCP_MASTER_EN_BIT          4
`define LCP_COM_EN_LOW_HI          3

// ------------------------------------------------------------
// field positions in lcd_common_role_select
// ------------------------------------------------------------
`define LCP_COM_EN_HIGH_HI         7
`define LCP_COM_EN_HIGH_LO         6
`define LCP_ROLE_HI                5

// ------------------------------------------------------------
// reset value and bias current codes
// ------------------------------------------------------------
`define LCP_REG_RESET              8'h00
`define LCP_BIAS_8U3               2'h0
`define LCP_BIAS_16U7              2'h1
`define LCP_BIAS_50U               2'h2
`define LCP_BIAS_100U              2'h3

// ------------------------------------------------------------
// drive level codes per pin: 00 vss, 01 one third, 10 two thirds, 11 vdd
// ------------------------------------------------------------
`define LCP_LVL_VSS                2'h0
`define LCP_LVL_THIRD              2'h1
`define LCP_LVL_TWO_THIRDS         2'h2
`define LCP_LVL_VDD                2'h3

`endif

// File: hdl/lcp_pin_ctrl.v
// lcd common/segment pin control register bank with per-pin level select
// Functional notes
// - bit 7 selects frame 0 or 1
// - bits 6..5 select bias current level
// - bit 4 master enable gates pin enables
// - master off forces all outputs to vss; here levels go to vss but every pin select clears, releasing the pins
// - common enables 0..3 and 4..5 placed
// - role bits 0..5: common or segment
// - segment enables 6..13 in third register
// - small variant fourth register top bits zero
// - fifth register bits 7..2 read zero
// - pin taken only when its bit set
// - frame sets common and segment level pairs
// - io data bit picks full or bias
// - no port direction needed beforehand
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps

module lcp_pin_ctrl #(
	parameter LARGE_VARIANT = 1
) (
	// clock and reset
	input  wire        clk_sys_i,
	input  wire        rstn_i,
	// register port
	input  wire [2:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [7:0]  reg_rdata_o,
	// shared io data bits from the port pins
	input  wire [23:0] io_data_i,
	// pin function and drive level
	output reg  [23:0] lcd_pin_select_o,
	output reg  [23:0] lcd_pin_is_segment_o,
	output reg  [47:0] lcd_pin_level_o,
	output reg  [1:0]  bias_current_select_o,
	output reg         lcd_master_enable_o
);
`include "lcp_map.vh"

	localparam NPIN = 24;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	reg  [7:0]  main_control_reg;
	reg  [7:0]  common_role_reg;
	reg  [7:0]  seg_enable_low_reg;
	reg  [7:0]  seg_enable_mid_reg;
	reg  [7:0]  seg_enable_high_reg;
	reg  [23:0] io_meta_reg;
	reg  [23:0] io_sync_reg;

	reg  [7:0]  mid_mask;
	reg  [7:0]  high_mask;
	reg  [7:0]  rdata_next;
	reg  [23:0] pin_en_raw;
	reg  [23:0] segment_role;
	wire [47:0] level_next;

	// ------------------------------------------------------------
	// variant masks
	// ------------------------------------------------------------
	always @* begin
		// fifth register low two bits only in the large variant, no bits in the small one
		if (LARGE_VARIANT != 0) begin
			mid_mask  = 8'hFF;
			high_mask = 8'h03;
		end else begin
			mid_mask  = 8'h3F;
			high_mask = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// plain storage, clears to zero
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			main_control_reg    <= `LCP_REG_RESET;
			common_role_reg     <= `LCP_REG_RESET;
			seg_enable_low_reg  <= `LCP_REG_RESET;
			seg_enable_mid_reg  <= `LCP_REG_RESET;
			seg_enable_high_reg <= `LCP_REG_RESET;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`LCP_MAIN_CONTROL_ADDR:    main_control_reg    <= reg_wdata_i;
				`LCP_COMMON_ROLE_ADDR:     common_role_reg     <= reg_wdata_i;
				`LCP_SEG_ENABLE_LOW_ADDR:  seg_enable_low_reg  <= reg_wdata_i;
				`LCP_SEG_ENABLE_MID_ADDR:  seg_enable_mid_reg  <= reg_wdata_i & mid_mask;
				`LCP_SEG_ENABLE_HIGH_ADDR: seg_enable_high_reg <= reg_wdata_i & high_mask;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// read path, data one cycle after the strobe
	// ------------------------------------------------------------
	always @* begin
		case (reg_addr_i)
			`LCP_MAIN_CONTROL_ADDR:    rdata_next = main_control_reg;
			`LCP_COMMON_ROLE_ADDR:     rdata_next = common_role_reg;
			`LCP_SEG_ENABLE_LOW_ADDR:  rdata_next = seg_enable_low_reg;
			`LCP_SEG_ENABLE_MID_ADDR:  rdata_next = seg_enable_mid_reg & mid_mask;
			`LCP_SEG_ENABLE_HIGH_ADDR: rdata_next = seg_enable_high_reg & high_mask;
			// live state: master enable and bias as applied, low five bits zero
			`LCP_PIN_STATUS_ADDR:      rdata_next = {lcd_master_enable_o,
			                                          bias_current_select_o, 5'h00};
			default:                   rdata_next = `LCP_UNMAPPED_DATA;
		endcase
	end

	always @(posedge clk_sys_i) begin
		if (!rstn_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= rdata_next;
		else
			reg_rdata_o <= 8'h00;
	end

	// ------------------------------------------------------------
	// pin enable and role mapping
	// ------------------------------------------------------------
	always @* begin
		pin_en_raw[3:0]   = main_control_reg[`LCP_COM_EN_LOW_HI:0];
		pin_en_raw[5:4]   = common_role_reg[`LCP_COM_EN_HIGH_HI:`LCP_COM_EN_HIGH_LO];
		pin_en_raw[13:6]  = seg_enable_low_reg;
		pin_en_raw[21:14] = seg_enable_mid_reg & mid_mask;
		pin_en_raw[23:22] = seg_enable_high_reg[1:0] & high_mask[1:0];
		segment_role[5:0]  = common_role_reg[`LCP_ROLE_HI:0];
		segment_role[23:6] = 18'h3FFFF;
	end

	// ------------------------------------------------------------
	// io data synchroniser, pins are outside the clock domain
	// ------------------------------------------------------------
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			io_meta_reg <= 24'h000000;
			io_sync_reg <= 24'h000000;
		end else begin
			io_meta_reg <= io_data_i;
			io_sync_reg <= io_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// level selection per pin
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
			lcp_level_sel u_sel (
				.master_en_i  (main_control_reg[`LCP_MASTER_EN_BIT]),
				.frame_i      (main_control_reg[`LCP_FRAME_BIT]),
				.pin_en_i     (pin_en_raw[gi]),
				.is_segment_i (segment_role[gi]),
				.io_data_i    (io_sync_reg[gi]),
				.level_o      (level_next[2*gi+1:2*gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			lcd_pin_select_o      <= 24'h000000;
			lcd_pin_is_segment_o  <= 24'h000000;
			lcd_pin_level_o       <= 48'h000000000000;
			bias_current_select_o <= `LCP_BIAS_8U3;
			lcd_master_enable_o   <= 1'h0;
		end else begin
			lcd_pin_select_o      <= main_control_reg[`LCP_MASTER_EN_BIT] ?
			                         pin_en_raw : 24'h000000;
			lcd_pin_is_segment_o  <= segment_role;
			lcd_pin_level_o       <= level_next;
			bias_current_select_o <= main_control_reg[`LCP_BIAS_SEL_HI:`LCP_BIAS_SEL_LO];
			lcd_master_enable_o   <= main_control_reg[`LCP_MASTER_EN_BIT];
		end
	end

endmodule // lcp_pin_ctrl
